// ---- pfa_pkg.sv ----
`default_nettype none
package pfa_pkg;
   // Packet framing on the link
   localparam int          WORD_W       = 32;
   localparam int          ID_MSB       = 31;
   localparam int          ID_LSB       = 24;
   localparam logic [4:0]  LAST_BIT     = 5'h1f;
   // Frame assignment packets: ids 32..39
   localparam logic [4:0]  FRAME_ID_TOP = 5'h04;
   localparam int          FRAME_TOP_LSB = 27;
   localparam int          RANGE_MSB    = 26;
   localparam int          RANGE_LSB    = 24;
   localparam int          GROUP_W      = 16;
   localparam int          NUM_FRAMES   = 128;
   // User address enable packet: id 120
   localparam logic [7:0]  ENABLE_ID    = 8'h78;
   // User address assignment packets: ids 128..143
   localparam logic [3:0]  ASSIGN_ID_TOP = 4'h8;
   localparam int          ASSIGN_TOP_LSB = 28;
   localparam int          INDEX_MSB    = 27;
   localparam int          INDEX_LSB    = 24;
   localparam int          LONG_BIT     = 22;
   localparam int          TONE_BIT     = 21;
   localparam int          ADDR_W       = 21;
   localparam int          NUM_WORDS    = 16;
   // Reset values
   localparam logic [NUM_FRAMES-1:0] FRAMES_RST = 128'h0;
   localparam logic [NUM_WORDS-1:0]  ENABLE_RST = 16'h0;
   localparam logic [NUM_WORDS-1:0]  FLAGS_RST  = 16'h0;
   localparam logic [ADDR_W-1:0]     ADDR_RST   = 21'h0;
   localparam logic [WORD_W-1:0]     WORD_RST   = 32'h0;
endpackage : pfa_pkg
`default_nettype wire

// ---- pfa_config.sv ----
// What this block does
// - Accept frame packets, ids 32 to 39
// - Range selector picks sixteen frames, descending order
// - Set bit marks frame assigned; reset clears
// - Manual collapse: collapse not applied to frames
// - Enable packet id 120, sixteen bits, reset zero
// - Enable bit n governs word id 128+n
// - Sixteen words, long and tone flags stored
// - Word number selects word and report index
// - Tone-only word suppresses vector decode
// - Store 21-bit address value as match word
`timescale 1ns/1ps
`default_nettype none
module pfa_config (
   input  wire logic                           sys_clk,
   input  wire logic                           rstn,
   input  wire logic                           link_sck,
   input  wire logic                           link_ss_n,
   input  wire logic                           link_mosi,
   input  wire logic                           manual_collapse_select,
   input  wire logic                           collapse_valid,
   input  wire logic [pfa_pkg::NUM_FRAMES-1:0] collapse_mask,
   input  wire logic                           addr_hit,
   input  wire logic [3:0]                     hit_index,
   output logic [pfa_pkg::NUM_FRAMES-1:0]      assigned_frame_bits,
   output logic [pfa_pkg::NUM_FRAMES-1:0]      frame_decode,
   output logic [pfa_pkg::NUM_WORDS-1:0]       user_word_enable_bits,
   output logic [pfa_pkg::NUM_WORDS-1:0][pfa_pkg::ADDR_W-1:0] word_address,
   output logic [pfa_pkg::NUM_WORDS-1:0]       long_pair_flag,
   output logic [pfa_pkg::NUM_WORDS-1:0]       tone_only_flag,
   output logic                                vector_decode_req,
   output logic [3:0]                          reported_word_index
);

   // Link side: shift in 32 bits, msb first
   logic [30:0] shift_r;
   logic [30:0] shift_nxt;
   logic [4:0]  cnt_r;
   logic [4:0]  cnt_nxt;
   logic [31:0] hold_r;
   logic [31:0] hold_nxt;
   logic        tog_r;
   logic        tog_nxt;

   always_comb begin
      shift_nxt = {shift_r[29:0], link_mosi};
      cnt_nxt   = cnt_r + 5'h01;
      hold_nxt  = hold_r;
      tog_nxt   = tog_r;
      if (cnt_r == pfa_pkg::LAST_BIT) begin
         hold_nxt = {shift_r, link_mosi};
         tog_nxt  = ~tog_r;
      end
   end

   // Deselect realigns the bit count; the link clock may stop between words
   always_ff @(posedge link_sck or negedge rstn or posedge link_ss_n) begin
      if (!rstn) begin
         cnt_r <= 5'h00;
      end else if (link_ss_n) begin
         cnt_r <= 5'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge link_sck or negedge rstn) begin
      if (!rstn) begin
         shift_r <= 31'h0;
         hold_r  <= pfa_pkg::WORD_RST;
         tog_r   <= 1'b0;
      end else if (!link_ss_n) begin
         shift_r <= shift_nxt;
         hold_r  <= hold_nxt;
         tog_r   <= tog_nxt;
      end
   end

   // Toggle crossing; hold_r is stable for a whole word after the toggle
   logic [2:0] sync_r;
   logic [2:0] sync_nxt;
   logic       pkt_stb;
   logic [31:0] pkt;

   always_comb begin
      sync_nxt = {sync_r[1:0], tog_r};
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sync_r <= 3'h0;
      end else begin
         sync_r <= sync_nxt;
      end
   end

   assign pkt_stb = sync_r[2] ^ sync_r[1];
   assign pkt     = hold_r;

   // Packet decode
   logic is_frame;
   logic is_enable;
   logic is_assign;
   logic [6:0] frame_base;
   logic [3:0] word_sel;

   assign is_frame  = pkt_stb &&
      (pkt[pfa_pkg::ID_MSB:pfa_pkg::FRAME_TOP_LSB] ==
       pfa_pkg::FRAME_ID_TOP);
   assign is_enable = pkt_stb &&
      (pkt[pfa_pkg::ID_MSB:pfa_pkg::ID_LSB] ==
       pfa_pkg::ENABLE_ID);
   assign is_assign = pkt_stb &&
      (pkt[pfa_pkg::ID_MSB:pfa_pkg::ASSIGN_TOP_LSB] ==
       pfa_pkg::ASSIGN_ID_TOP);
   // Selector 0 lands on frames 127..112, 7 on frames 15..0
   assign frame_base = {~pkt[pfa_pkg::RANGE_MSB:pfa_pkg::RANGE_LSB],
                        4'h0};
   assign word_sel   = pkt[pfa_pkg::INDEX_MSB:pfa_pkg::INDEX_LSB];

   // Configuration state
   logic [pfa_pkg::NUM_FRAMES-1:0] af_r;
   logic [pfa_pkg::NUM_FRAMES-1:0] af_nxt;
   logic [pfa_pkg::NUM_FRAMES-1:0] decode_r;
   logic [pfa_pkg::NUM_FRAMES-1:0] decode_nxt;
   logic [pfa_pkg::NUM_WORDS-1:0]  uae_r;
   logic [pfa_pkg::NUM_WORDS-1:0]  uae_nxt;
   logic [pfa_pkg::NUM_WORDS-1:0][pfa_pkg::ADDR_W-1:0] addr_r;
   logic [pfa_pkg::NUM_WORDS-1:0][pfa_pkg::ADDR_W-1:0] addr_nxt;
   logic [pfa_pkg::NUM_WORDS-1:0]  long_r;
   logic [pfa_pkg::NUM_WORDS-1:0]  long_nxt;
   logic [pfa_pkg::NUM_WORDS-1:0]  tone_r;
   logic [pfa_pkg::NUM_WORDS-1:0]  tone_nxt;
   logic                           vec_r;
   logic                           vec_nxt;
   logic [3:0]                     idx_r;
   logic [3:0]                     idx_nxt;

   always_comb begin
      af_nxt   = af_r;
      uae_nxt  = uae_r;
      addr_nxt = addr_r;
      long_nxt = long_r;
      tone_nxt = tone_r;
      if (is_frame) begin
         af_nxt[frame_base +: pfa_pkg::GROUP_W] = pkt[15:0];
      end
      if (is_enable) begin
         uae_nxt = pkt[15:0];
      end
      if (is_assign) begin
         addr_nxt[word_sel] = pkt[pfa_pkg::ADDR_W-1:0];
         long_nxt[word_sel] = pkt[pfa_pkg::LONG_BIT];
         tone_nxt[word_sel] = pkt[pfa_pkg::TONE_BIT];
      end
      // Manual mode keeps the host's frame set untouched
      if (!manual_collapse_select && collapse_valid) begin
         decode_nxt = af_r & collapse_mask;
      end else begin
         decode_nxt = af_r;
      end
      // Enabled, non tone-only words ask for a vector decode
      vec_nxt = addr_hit && uae_r[hit_index] &&
                !tone_r[hit_index];
      idx_nxt = addr_hit ? hit_index : idx_r;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         af_r     <= pfa_pkg::FRAMES_RST;
         decode_r <= pfa_pkg::FRAMES_RST;
         uae_r    <= pfa_pkg::ENABLE_RST;
         addr_r   <= {pfa_pkg::NUM_WORDS{pfa_pkg::ADDR_RST}};
         long_r   <= pfa_pkg::FLAGS_RST;
         tone_r   <= pfa_pkg::FLAGS_RST;
         vec_r    <= 1'b0;
         idx_r    <= 4'h0;
      end else begin
         af_r     <= af_nxt;
         decode_r <= decode_nxt;
         uae_r    <= uae_nxt;
         addr_r   <= addr_nxt;
         long_r   <= long_nxt;
         tone_r   <= tone_nxt;
         vec_r    <= vec_nxt;
         idx_r    <= idx_nxt;
      end
   end

   assign assigned_frame_bits   = af_r;
   assign frame_decode          = decode_r;
   assign user_word_enable_bits = uae_r;
   assign word_address          = addr_r;
   assign long_pair_flag        = long_r;
   assign tone_only_flag        = tone_r;
   assign vector_decode_req     = vec_r;
   assign reported_word_index   = idx_r;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_frame_pkt;
      is_frame;
   endsequence

   sequence s_assign_pkt;
      is_assign;
   endsequence

   a_frame_load: assert property (
      s_frame_pkt |=> af_r[$past(frame_base) +: 16] == $past(pkt[15:0]))
      else $error("frame packet bits not stored");

   a_frame_range: assert property (
      s_frame_pkt ##0 (pkt[26:24] == 3'h7) |=>
      af_r[127:16] == $past(af_r[127:16]) && af_r[15:0] == $past(pkt[15:0]))
      else $error("frame range selector maps wrong frames");

   a_frame_reset: assert property (
      @(posedge sys_clk) disable iff (1'b0)
      !rstn |-> af_r == '0 && uae_r == '0)
      else $error("frame or enable bits not clear in reset");

   a_manual_hold: assert property (
      manual_collapse_select |=> decode_r == $past(af_r))
      else $error("collapse applied in manual mode");

   a_enable_load: assert property (
      is_enable |=> uae_r == $past(pkt[15:0]))
      else $error("enable packet not stored");

   a_enable_gates: assert property (
      addr_hit && !uae_r[hit_index] |=> !vector_decode_req)
      else $error("disabled word produced a vector request");

   a_word_store: assert property (
      s_assign_pkt |=> long_r[$past(word_sel)] == $past(pkt[22]) &&
      tone_r[$past(word_sel)] == $past(pkt[21]))
      else $error("word flags not stored");

   a_index_report: assert property (
      addr_hit |=> reported_word_index == $past(hit_index))
      else $error("reported index differs from hit word");

   a_tone_blocks: assert property (
      addr_hit && tone_r[hit_index] |=> !vector_decode_req)
      else $error("tone-only word requested a vector");

   a_addr_value: assert property (
      s_assign_pkt |=> addr_r[$past(word_sel)] == $past(pkt[20:0]))
      else $error("address value not stored");

   a_id_ignore: assert property (
      pkt_stb && !is_frame && !is_enable && !is_assign |=>
      $stable(af_r) && $stable(uae_r) && $stable(addr_r))
      else $error("unknown packet changed state");

   sequence s_live_hit;
      addr_hit && uae_r[hit_index] && !tone_r[hit_index];
   endsequence

   a_vector_grant: assert property (
      s_live_hit |=> vector_decode_req)
      else $error("enabled word gave no vector request");

   a_vector_cause: assert property (
      vector_decode_req |-> $past(addr_hit))
      else $error("vector request without an address hit");

   a_collapse_apply: assert property (
      !manual_collapse_select && collapse_valid |=>
      decode_r == ($past(af_r) & $past(collapse_mask)))
      else $error("collapse not applied in automatic mode");

   a_frames_hold: assert property (
      !is_frame |=> $stable(af_r))
      else $error("frame bits changed without a frame packet");

   a_enable_hold: assert property (
      !is_enable |=> $stable(uae_r))
      else $error("enable bits changed without an enable packet");

   a_word_hold: assert property (
      !is_assign |=>
      $stable(addr_r) && $stable(long_r) && $stable(tone_r))
      else $error("word changed without an assignment packet");

   a_index_hold: assert property (
      !addr_hit |=> $stable(reported_word_index))
      else $error("reported index changed without a hit");

   a_strobe_single: assert property (
      pkt_stb |=> !pkt_stb)
      else $error("packet strobe longer than one cycle");

endmodule : pfa_config
`default_nettype wire

// ---- pfa_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pfa_host_model (
   output logic link_sck,
   output logic link_ss_n,
   output logic link_mosi
);
   initial begin
      link_sck  = 1'b0;
      link_ss_n = 1'b1;
      link_mosi = 1'b0;
   end
   // One 32-bit packet, msb first, clock still outside frames
   task automatic send(input logic [31:0] w);
      #13;
      link_ss_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         link_mosi = w[i];
         #32 link_sck = 1'b1;
         #32 link_sck = 1'b0;
      end
      link_ss_n = 1'b1;
      // Released line shows no stale bit
      link_mosi = ~link_mosi;
      #64;
   endtask : send
endmodule : pfa_host_model
`default_nettype wire

// ---- pfa_config_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pfa_config_tb;
   logic              sys_clk, rstn, sck, ss_n, mosi, vreq;
   logic              man_sel, col_valid, addr_hit;
   logic [127:0]      col_mask, af, fdec, exp_af;
   logic [3:0]        hit_index, rep_idx, kb;
   logic [15:0]       en, lng, tone, exp_en, d, exp_tn;
   logic [15:0][20:0] waddr;
   logic [20:0]       ad;
   int                mismatches, n_checks;

   always #5 sys_clk = ~sys_clk;

   pfa_host_model pfa_host_model_i (.link_sck(sck), .link_ss_n(ss_n),
      .link_mosi(mosi));
   pfa_config pfa_config_i (.sys_clk(sys_clk), .rstn(rstn),
      .link_sck(sck), .link_ss_n(ss_n), .link_mosi(mosi),
      .manual_collapse_select(man_sel), .collapse_valid(col_valid),
      .collapse_mask(col_mask), .addr_hit(addr_hit),
      .hit_index(hit_index), .assigned_frame_bits(af),
      .frame_decode(fdec), .user_word_enable_bits(en),
      .word_address(waddr), .long_pair_flag(lng),
      .tone_only_flag(tone), .vector_decode_req(vreq),
      .reported_word_index(rep_idx));

   task automatic chk(input string nm, input logic [127:0] e, g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic pkt(input logic [31:0] w);
      pfa_host_model_i.send(w);
      repeat (8) @(posedge sys_clk);
      #1;
   endtask : pkt

   task automatic hit(input logic [3:0] k);
      @(posedge sys_clk);
      #1;
      addr_hit  = 1'b1;
      hit_index = k;
      @(posedge sys_clk);
      #1;
      addr_hit  = 1'b0;
   endtask : hit

   task automatic settle;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : settle

   task print_verdict;
      if (mismatches == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict

   initial begin
      #300000;
      mismatches++;
      print_verdict();
   end

   initial begin
      sys_clk    = 1'b0;
      rstn       = 1'b0;
      man_sel    = 1'b0;
      col_valid  = 1'b0;
      col_mask   = {4{32'hf0f0a55a}};
      addr_hit   = 1'b0;
      hit_index  = 4'h0;
      mismatches = 0;
      n_checks   = 0;
      exp_af     = 128'h0;
      exp_tn     = 16'hf0f0;
      repeat (4) @(posedge sys_clk);
      #1 rstn = 1'b1;
      chk("frames", 128'h0, af);
      chk("enables", 128'h0, en);
      for (int f = 0; f < 8; f++) begin
         d = 16'h8001 ^ 16'(f * 16'h1235);
         exp_af[(7-f)*16 +: 16] = d;
         pkt({5'h04, 3'(f), 8'h00, d});
         chk("frames", exp_af, af);
      end
      chk("decode", exp_af, fdec);
      col_valid = 1'b1;
      settle();
      chk("decode", exp_af & col_mask, fdec);
      man_sel = 1'b1;
      settle();
      chk("decode", exp_af, fdec);
      pkt(32'h28111111);
      pkt(32'h77111111);
      chk("frames", exp_af, af);
      chk("enables", 128'h0, en);
      // Long pairs even then next, tone equal in both halves
      for (int k = 0; k < 16; k++) begin
         kb = 4'(k);
         ad = 21'h1f0f0 ^ 21'(k * 21'h01357);
         pkt({4'h8, kb, 1'b0, kb[1], kb[2], ad});
         chk("address", ad, waddr[k]);
      end
      chk("long", 16'hcccc, lng);
      chk("tone", exp_tn, tone);
      exp_en = 16'ha5c3;
      pkt({8'h78, 8'h00, exp_en});
      chk("enables", exp_en, en);
      for (int k = 0; k < 16; k++) begin
         hit(4'(k));
         chk("vector", exp_en[k] & ~exp_tn[k], vreq);
         chk("index", k, rep_idx);
      end
      exp_en[0] = 1'b0;
      pkt({8'h78, 8'h00, exp_en});
      chk("enables", exp_en, en);
      pkt({8'h80, 3'b001, 21'h0abcd});
      chk("address", 21'h0abcd, waddr[0]);
      chk("tone", 16'hf0f1, tone);
      exp_en[0] = 1'b1;
      pkt({8'h78, 8'h00, exp_en});
      hit(4'h0);
      chk("vector", 1'b0, vreq);
      // Mid-run reset clears what the host wrote
      rstn = 1'b0;
      settle();
      chk("frames", 128'h0, af);
      chk("enables", 128'h0, en);
      chk("decode", 128'h0, fdec);
      rstn = 1'b1;
      pkt({5'h04, 3'h7, 8'h00, 16'h0001});
      chk("frames", 128'h1, af);
      print_verdict();
   end
endmodule : pfa_config_tb
`default_nettype wire
